// ===== core/t16co_pkg.sv
// Package for the 16-bit timer compare-output block.
// Assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock.
package t16co_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FORCE = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_CMPA = 8'h0C;
    localparam logic [7:0] ADDR_CMPB = 8'h10;
    localparam logic [7:0] ADDR_CAPT = 8'h14;
    localparam logic [7:0] ADDR_FLAGS = 8'h18;
    localparam logic [7:0] ADDR_PORT = 8'h1C;
    localparam int CTRL_WGM_LSB = 0;
    localparam int CTRL_COMA_LSB = 4;
    localparam int CTRL_COMB_LSB = 6;
    localparam int CTRL_CS_LSB = 8;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    localparam int FLAG_CAPT = 3;
    localparam int PORT_DIR_LSB = 2;
    localparam int PORT_OC_LSB = 4;
    localparam logic [10:0] CTRL_RESET = 11'h000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
    localparam logic [3:0] WGM_CTC_CAPT = 4'hC;
    localparam logic [1:0] COM_NONE = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Prescale masks for divide by 1, 8, 64, 256, 1024
    localparam logic [9:0] PSC_MASK_1 = 10'h000;
    localparam logic [9:0] PSC_MASK_8 = 10'h007;
    localparam logic [9:0] PSC_MASK_64 = 10'h03F;
    localparam logic [9:0] PSC_MASK_256 = 10'h0FF;
    localparam logic [9:0] PSC_MASK_1024 = 10'h3FF;
endpackage

// ===== core/t16co_timer.sv
// 16-bit timer: normal and clear-on-match counting, compare-output pin logic.
// Assumes an AXI4-Lite master, synchronous inputs and one clock domain.
// Operation
// - On a compare match in non-PWM modes, update each output-state bit per its output mode.
// - Reset clears every output-state bit to zero.
// - Nonzero output mode makes the output-state bit replace the port value.
// - Output-state value drives the pin only while direction selects output.
// - Output-state bit can be preset before the pin is made an output.
// - Output mode never affects the capture function.
// - Output mode zero leaves the output-state bit unchanged at matches.
// - A new output mode acts first at the next compare match.
// - In non-PWM modes the force strobe applies the output action at once.
// - Waveform mode sets the count sequence; output mode never does.
// - In non-PWM modes output mode selects set, clear or toggle.
// - Normal mode counts up only, wrapping 0xFFFF to 0x0000.
// - Normal mode sets overflow flag as counter becomes zero; counting never clears it.
// - Overflow interrupt execution clears the overflow flag.
// - Normal mode accepts a counter write at any time.
// - Clear-on-match clears counter at top: compare A in mode 4, capture in 12.
// - Reaching top sets the compare A or capture flag, whichever defines top.
// - Top register writes act directly, no double buffering.
// - Top written below the count is missed until wrap through 0xFFFF.
// - Channel A mode 1 toggles channel A state each match in clear-on-match.
// - Pin frequency is clock over 2*N*(1+compare A), N from 1..1024.
// - Clear-on-match sets overflow as counter passes maximum to 0x0000.
// - Counter equal to compare value sets that channel's flag at the tick.
// - Forced compare sets no flag and leaves the counter alone.
// - A counter write blocks all compare matches at the next timer tick.
`timescale 1ns/10ps
module t16co_timer import t16co_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_capture_event,
    input wire logic [3:0] i_flag_ack,
    output logic [3:0] o_flags,
    output logic o_pin_a_out,
    output logic o_pin_a_oe,
    output logic o_pin_b_out,
    output logic o_pin_b_oe
);
    logic aw_hold_r, w_hold_r, do_write, block_r, tick, is_ctc, non_pwm;
    logic match_a, match_b, top_hit, wr_ctrl, wr_force, wr_cnt, wr_flags;
    logic [1:0] oc_r, com_a, com_b;
    logic [2:0] cs;
    logic [3:0] wstrb_r, flags_r, port_r, wgm, flag_set, flag_clr;
    logic [7:0] awaddr_r;
    logic [9:0] psc_r, psc_mask;
    logic [10:0] ctrl_r;
    logic [15:0] cnt_r, cmpa_r, cmpb_r, cap_r, top;
    logic [31:0] wdata_r, wr_word, wr_mask;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic apply_action(input logic [1:0] com, input logic cur);
        case (com)
            COM_TOGGLE: apply_action = ~cur;
            COM_CLEAR: apply_action = 1'b0;
            COM_SET: apply_action = 1'b1;
            default: apply_action = cur;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= ADDR_PORT);
    endfunction

    assign wgm = ctrl_r[CTRL_WGM_LSB +: 4];
    assign com_a = ctrl_r[CTRL_COMA_LSB +: 2];
    assign com_b = ctrl_r[CTRL_COMB_LSB +: 2];
    assign cs = ctrl_r[CTRL_CS_LSB +: 3];
    assign is_ctc = (wgm == WGM_CTC_CMPA) || (wgm == WGM_CTC_CAPT);
    assign non_pwm = (wgm == WGM_NORMAL) || is_ctc;
    // Top register read live, so a rewrite below the count is simply missed
    assign top = (wgm == WGM_CTC_CAPT) ? cap_r : cmpa_r;

    // AXI4-Lite write path: address and data taken in either order
    assign do_write = aw_hold_r && w_hold_r && !o_bvalid;
    assign wr_word = merge(32'h0000_0000, wdata_r, wstrb_r);
    assign wr_mask = merge(32'h0000_0000, 32'hFFFF_FFFF, wstrb_r);
    assign wr_ctrl = do_write && (awaddr_r == ADDR_CTRL);
    assign wr_force = do_write && (awaddr_r == ADDR_FORCE);
    assign wr_cnt = do_write && (awaddr_r == ADDR_COUNT);
    assign wr_flags = do_write && (awaddr_r == ADDR_FLAGS);

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            aw_hold_r <= 1'b0;
            o_awready <= 1'b1;
            awaddr_r <= 8'h00;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_hold_r <= 1'b1;
                o_awready <= 1'b0;
                awaddr_r <= i_awaddr;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                o_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            w_hold_r <= 1'b0;
            o_wready <= 1'b1;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (i_wvalid && o_wready) begin
                w_hold_r <= 1'b1;
                o_wready <= 1'b0;
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Read path: one-cycle answer, no read side effects
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (i_araddr)
                ADDR_CTRL: o_rdata <= {21'h0, ctrl_r};
                ADDR_COUNT: o_rdata <= {16'h0000, cnt_r};
                ADDR_CMPA: o_rdata <= {16'h0000, cmpa_r};
                ADDR_CMPB: o_rdata <= {16'h0000, cmpb_r};
                ADDR_CAPT: o_rdata <= {16'h0000, cap_r};
                ADDR_FLAGS: o_rdata <= {28'h0000000, flags_r};
                ADDR_PORT: o_rdata <= {26'h0, oc_r, port_r};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // Software-written registers; top values have no buffer stage
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            ctrl_r <= CTRL_RESET;
            cmpa_r <= CNT_RESET;
            cmpb_r <= CNT_RESET;
            port_r <= 4'h0;
        end else if (do_write) begin
            case (awaddr_r)
                ADDR_CTRL: ctrl_r <= (ctrl_r & ~wr_mask[10:0]) | wr_word[10:0];
                ADDR_CMPA: cmpa_r <= (cmpa_r & ~wr_mask[15:0]) | wr_word[15:0];
                ADDR_CMPB: cmpb_r <= (cmpb_r & ~wr_mask[15:0]) | wr_word[15:0];
                ADDR_PORT: port_r <= (port_r & ~wr_mask[3:0]) | wr_word[3:0];
                default: ;
            endcase
        end
    end

    // Prescaler: one enable pulse per N clocks
    always_comb begin
        case (cs)
            3'd1: psc_mask = PSC_MASK_1;
            3'd2: psc_mask = PSC_MASK_8;
            3'd3: psc_mask = PSC_MASK_64;
            3'd4: psc_mask = PSC_MASK_256;
            3'd5: psc_mask = PSC_MASK_1024;
            default: psc_mask = PSC_MASK_1;
        endcase
    end
    assign tick = (cs >= 3'd1) && (cs <= 3'd5) && ((psc_r & psc_mask) == psc_mask);

    always_ff @(posedge i_mclk) begin
        if (!i_resetn || cs == 3'd0) begin
            psc_r <= 10'h000;
        end else begin
            psc_r <= psc_r + 10'h001;
        end
    end

    // A counter write masks matches for the following tick, even when stopped
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            block_r <= 1'b0;
        end else if (wr_cnt) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end

    assign match_a = (cnt_r == cmpa_r) && !block_r;
    assign match_b = (cnt_r == cmpb_r) && !block_r;
    assign top_hit = is_ctc && (cnt_r == top) && !block_r;

    // Unsupported PWM codes count as normal mode
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            cnt_r <= CNT_RESET;
        end else if (wr_cnt) begin
            cnt_r <= (cnt_r & ~wr_mask[15:0]) | wr_word[15:0];
        end else if (tick) begin
            if (top_hit) begin
                cnt_r <= CNT_BOTTOM;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // Capture ignores output modes; disabled while capture register is top
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            cap_r <= CNT_RESET;
        end else if (do_write && awaddr_r == ADDR_CAPT) begin
            cap_r <= (cap_r & ~wr_mask[15:0]) | wr_word[15:0];
        end else if (i_capture_event && wgm != WGM_CTC_CAPT) begin
            cap_r <= cnt_r;
        end
    end

    always_comb begin
        flag_set = 4'h0;
        if (tick && !wr_cnt && cnt_r == CNT_MAX) begin
            flag_set[FLAG_OVF] = 1'b1;
        end
        if (tick && match_a) begin
            flag_set[FLAG_CMPA] = 1'b1;
        end
        if (tick && match_b) begin
            flag_set[FLAG_CMPB] = 1'b1;
        end
        if (tick && top_hit && wgm == WGM_CTC_CAPT) begin
            flag_set[FLAG_CAPT] = 1'b1;
        end
        if (i_capture_event && wgm != WGM_CTC_CAPT) begin
            flag_set[FLAG_CAPT] = 1'b1;
        end
        flag_clr = i_flag_ack | (wr_flags ? wr_word[3:0] : 4'h0);
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            flags_r <= 4'h0;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end
    assign o_flags = flags_r;

    // Output-state bits: match actions on ticks, forced actions at once
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            oc_r <= 2'b00;
        end else if (non_pwm) begin
            if (wr_force && wr_word[0]) begin
                oc_r[0] <= apply_action(com_a, oc_r[0]);
            end else if (tick && match_a) begin
                oc_r[0] <= apply_action(com_a, oc_r[0]);
            end
            if (wr_force && wr_word[1]) begin
                oc_r[1] <= apply_action(com_b, oc_r[1]);
            end else if (tick && match_b) begin
                oc_r[1] <= apply_action(com_b, oc_r[1]);
            end
        end
    end

    // Pin mux: override value, direction always from the port bit
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_pin_a_out <= 1'b0;
            o_pin_b_out <= 1'b0;
            o_pin_a_oe <= 1'b0;
            o_pin_b_oe <= 1'b0;
        end else begin
            o_pin_a_out <= (com_a != COM_NONE) ? oc_r[0] : port_r[0];
            o_pin_b_out <= (com_b != COM_NONE) ? oc_r[1] : port_r[1];
            o_pin_a_oe <= port_r[PORT_DIR_LSB];
            o_pin_b_oe <= port_r[PORT_DIR_LSB + 1];
        end
    end

    property p_reset_state;
        @(posedge i_mclk) $rose(i_resetn) |-> (oc_r == 2'b00 && o_pin_a_oe == 1'b0);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("output state not cleared");
    property p_override;
        @(posedge i_mclk) disable iff (!i_resetn)
        ($past(com_a) != COM_NONE && $past(i_resetn)) |-> (o_pin_a_out == $past(oc_r[0]));
    endproperty
    a_override: assert property (p_override) else $error("pin A not overridden");
    property p_dir;
        @(posedge i_mclk) disable iff (!i_resetn)
        $past(i_resetn) |-> (o_pin_b_oe == $past(port_r[PORT_DIR_LSB + 1]));
    endproperty
    a_dir: assert property (p_dir) else $error("pin B enable wrong");
    property p_mode_zero;
        @(posedge i_mclk) disable iff (!i_resetn)
        (com_a == COM_NONE && !wr_ctrl) |=> $stable(oc_r[0]);
    endproperty
    a_mode_zero: assert property (p_mode_zero) else $error("state moved with mode zero");
    property p_toggle;
        @(posedge i_mclk) disable iff (!i_resetn)
        (tick && match_a && is_ctc && com_a == COM_TOGGLE && !wr_force) |=> (oc_r[0] != $past(oc_r[0]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle on match");
    property p_wrap;
        @(posedge i_mclk) disable iff (!i_resetn)
        (tick && wgm == WGM_NORMAL && !wr_cnt && cnt_r == CNT_MAX) |=> (cnt_r == CNT_BOTTOM && flags_r[FLAG_OVF]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("normal wrap wrong");
    property p_ctc_clear;
        @(posedge i_mclk) disable iff (!i_resetn)
        (tick && top_hit && !wr_cnt) |=> (cnt_r == CNT_BOTTOM);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("no clear at top");
    property p_block;
        @(posedge i_mclk) disable iff (!i_resetn)
        (tick && block_r && !flags_r[FLAG_CMPA]) |=> !flags_r[FLAG_CMPA];
    endproperty
    a_block: assert property (p_block) else $error("match not blocked");
    property p_flag_set;
        @(posedge i_mclk) disable iff (!i_resetn)
        (tick && match_a) |=> flags_r[FLAG_CMPA];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("compare flag missed");
    property p_force;
        @(posedge i_mclk) disable iff (!i_resetn)
        (wr_force && !tick && !flags_r[FLAG_CMPA]) |=> (!flags_r[FLAG_CMPA] && $stable(cnt_r));
    endproperty
    a_force: assert property (p_force) else $error("force touched flag or count");
    property p_missed_top;
        @(posedge i_mclk) disable iff (!i_resetn)
        (tick && is_ctc && !wr_cnt && cnt_r > top && cnt_r != CNT_MAX) |=> (cnt_r == $past(cnt_r) + 16'h0001);
    endproperty
    a_missed_top: assert property (p_missed_top) else $error("missed top not counted");
    property p_tick_only;
        @(posedge i_mclk) disable iff (!i_resetn)
        (!tick && !wr_cnt) |=> $stable(cnt_r);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("count moved without tick");
endmodule

// ===== test/t16co_pin_model.sv
// Port pin model for the two compare-output pins of the timer.
// Assumes a pull-up on each pin, so an undriven pin reads high.
`timescale 1ns/10ps
module t16co_pin_model (
    input wire logic i_out_a,
    input wire logic i_oe_a,
    input wire logic i_out_b,
    input wire logic i_oe_b,
    output logic o_level_a,
    output logic o_level_b
);
    assign o_level_a = i_oe_a ? i_out_a : 1'b1;
    assign o_level_b = i_oe_b ? i_out_b : 1'b1;
endmodule

// ===== test/timer16_compare_output_normal_ctc_bench.sv
// Bench for the 16-bit timer compare-output block.
// Assumes the register map of t16co_pkg and a pulled-up pin model.
`timescale 1ns/10ps
module timer16_compare_output_normal_ctc_bench import t16co_pkg::*; ();
    localparam int TOP_A = 3;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF, flag_ack = 4'h0;
    logic capture_event = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pa_out, pa_oe, pb_out, pb_oe, lvl_a, lvl_b;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v;
    logic [3:0] flags;
    int err_count = 0;
    int checks_done = 0;
    int cyc;
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    t16co_timer DUT (.i_mclk(mclk), .i_resetn(resetn), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_capture_event(capture_event), .i_flag_ack(flag_ack), .o_flags(flags),
        .o_pin_a_out(pa_out), .o_pin_a_oe(pa_oe), .o_pin_b_out(pb_out), .o_pin_b_oe(pb_oe));
    t16co_pin_model pins (.i_out_a(pa_out), .i_oe_a(pa_oe), .i_out_b(pb_out), .i_oe_b(pb_oe),
        .o_level_a(lvl_a), .o_level_b(lvl_b));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Bready dropped one edge before the next call, so no signal is driven twice per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge mclk);
    endtask

    function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb,
                                        input logic [2:0] cs);
        ctl = {21'h0, cs, cb, ca, m};
    endfunction

    // Skips the first, partial interval and times the next one
    task automatic period(output int c);
        logic last;
        int n;
        n = 0;
        last = lvl_a;
        while (lvl_a === last && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        last = lvl_a;
        c = 0;
        while (lvl_a === last && c < 3000) begin
            @(posedge mclk);
            c++;
        end
    endtask

    initial begin
        #(CLK_PERIOD_NS * 20000);
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rd(ADDR_PORT, RESP_OKAY, v);
        chk(v, 32'h0);
        rd(8'h20, RESP_SLVERR, v);
        chk(v, 32'h0);
        wr(8'h20, 32'h1, RESP_SLVERR);
        // Preset both states with the timer stopped and the pins still inputs
        wr(ADDR_CTRL, ctl(WGM_NORMAL, COM_SET, COM_CLEAR, 3'h0));
        wr(ADDR_FORCE, 32'h3);
        rd(ADDR_PORT, RESP_OKAY, v);
        chk(v, 32'h10);
        chk({31'h0, pa_oe}, 32'h0);
        rd(ADDR_FLAGS, RESP_OKAY, v);
        chk(v, 32'h0);
        rd(ADDR_COUNT, RESP_OKAY, v);
        chk(v, 32'h0);
        wr(ADDR_PORT, 32'h0C);
        repeat (3) @(posedge mclk);
        chk({30'h0, lvl_b, lvl_a}, 32'h1);
        wr(ADDR_CTRL, ctl(WGM_NORMAL, COM_NONE, COM_TOGGLE, 3'h0));
        wr(ADDR_FORCE, 32'h3);
        rd(ADDR_PORT, RESP_OKAY, v);
        chk(v, 32'h3C);
        repeat (3) @(posedge mclk);
        chk({30'h0, lvl_b, lvl_a}, 32'h2);
        wr(ADDR_CTRL, ctl(WGM_NORMAL, COM_CLEAR, COM_SET, 3'h0));
        wr(ADDR_FORCE, 32'h3);
        rd(ADDR_PORT, RESP_OKAY, v);
        chk(v, 32'h2C);
        // Counter written equal to compare A: the first tick must not match
        wr(ADDR_CMPA, 32'h7);
        wr(ADDR_COUNT, 32'h7);
        wr(ADDR_FLAGS, 32'hF);
        wr(ADDR_CTRL, ctl(WGM_NORMAL, COM_TOGGLE, COM_NONE, 3'h1));
        repeat (4) @(posedge mclk);
        chk({28'h0, flags}, 32'h0);
        chk({31'h0, lvl_a}, 32'h0);
        wr(ADDR_COUNT, 32'hFFFD);
        repeat (4) @(posedge mclk);
        chk({31'h0, flags[FLAG_OVF]}, 32'h1);
        rd(ADDR_COUNT, RESP_OKAY, v);
        chk({31'h0, v < 32'h10}, 32'h1);
        flag_ack <= 4'h1;
        @(posedge mclk);
        flag_ack <= 4'h0;
        repeat (2) @(posedge mclk);
        chk({31'h0, flags[FLAG_OVF]}, 32'h0);
        repeat (20) @(posedge mclk);
        chk({31'h0, flags[FLAG_CMPA]}, 32'h1);
        chk({31'h0, lvl_a}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_TOGGLE, COM_NONE, 3'h0));
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_CMPA, 32'(TOP_A));
            wr(ADDR_FLAGS, 32'hF);
            wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_TOGGLE, COM_NONE, 3'(i + 1)));
            period(cyc);
            chk(32'(cyc), 32'((i == 0 ? 1 : 8) * (1 + TOP_A)));
            chk({31'h0, flags[FLAG_CMPA]}, 32'h1);
            rd(ADDR_COUNT, RESP_OKAY, v);
            chk({31'h0, v <= 32'(TOP_A)}, 32'h1);
        end
        // Top written below the count: match missed until the wrap
        wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_NONE, COM_NONE, 3'h0));
        wr(ADDR_COUNT, 32'hFFF0);
        wr(ADDR_CMPA, 32'h5);
        wr(ADDR_FLAGS, 32'hF);
        wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_NONE, COM_NONE, 3'h1));
        repeat (8) @(posedge mclk);
        chk({28'h0, flags}, 32'h0);
        repeat (30) @(posedge mclk);
        chk({30'h0, flags[FLAG_CMPA], flags[FLAG_OVF]}, 32'h3);
        wr(ADDR_CTRL, ctl(WGM_CTC_CAPT, COM_NONE, COM_NONE, 3'h0));
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_CAPT, 32'h2);
        wr(ADDR_FLAGS, 32'hF);
        wr(ADDR_CTRL, ctl(WGM_CTC_CAPT, COM_NONE, COM_NONE, 3'h1));
        repeat (10) @(posedge mclk);
        chk({30'h0, flags[FLAG_CMPA], flags[FLAG_CAPT]}, 32'h1);
        rd(ADDR_COUNT, RESP_OKAY, v);
        chk({31'h0, v <= 32'h2}, 32'h1);
        // Capture with both output modes active: loads the count, sets its flag
        wr(ADDR_CTRL, ctl(WGM_NORMAL, COM_TOGGLE, COM_TOGGLE, 3'h0));
        wr(ADDR_COUNT, 32'h1234);
        wr(ADDR_FLAGS, 32'hF);
        capture_event <= 1'b1;
        @(posedge mclk);
        capture_event <= 1'b0;
        rd(ADDR_CAPT, RESP_OKAY, v);
        chk(v, 32'h1234);
        chk({31'h0, flags[FLAG_CAPT]}, 32'h1);
        // Second reset in mid-run clears output states and port bits
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rd(ADDR_PORT, RESP_OKAY, v);
        chk(v, 32'h0);
        print_verdict();
    end
endmodule
